/* File: core/tss_defs.vh */
/*
 Constants for the transient step trigger sequencer: register offsets,
 field positions, reset values and timing.
 Assumes inclusion by bare name from core/ sources.
*/
`ifndef TSS_DEFS_VH
`define TSS_DEFS_VH

// ==========================================================
// Register offsets (byte addresses)
`define TSS_OFF_CTRL 8'h00
`define TSS_OFF_CMD 8'h04
`define TSS_OFF_IMM_V 8'h08
`define TSS_OFF_IMM_I 8'h0c
`define TSS_OFF_TRG_V 8'h10
`define TSS_OFF_TRG_I 8'h14
`define TSS_OFF_OPER_COND 8'h18
`define TSS_OFF_IRQ_STAT 8'h1c
`define TSS_OFF_IRQ_EN 8'h20
`define TSS_OFF_IRQ_CLR 8'h24

// ==========================================================
// Field positions
`define TSS_CTRL_VMODE_BIT 0
`define TSS_CTRL_IMODE_BIT 1
`define TSS_CMD_INIT_BIT 0
`define TSS_CMD_ABORT_BIT 1
`define TSS_CMD_TRIG_BIT 2
`define TSS_CMD_STRG_BIT 3
`define TSS_CMD_GET_BIT 4
`define TSS_COND_WTG_BIT 4
`define TSS_COND_ACTIVE_BIT 6
`define TSS_IRQ_READY_BIT 0
`define TSS_IRQ_STEP_BIT 1
`define TSS_IRQ_DROP_BIT 2
`define TSS_IRQ_ABORT_BIT 3

// ==========================================================
// Reset values
`define TSS_RST_LEVEL 16'h0000
`define TSS_RST_CTRL 2'h0
`define TSS_RST_IRQ 4'h0

// ==========================================================
// Timing
`define TSS_CLK_HZ 10000000
`define TSS_READY_US 3000
`define TSS_READY_CYC ((`TSS_READY_US * (`TSS_CLK_HZ / 1000000)))

`endif

/* File: core/tss_sequencer.v */
/*
 Transient step trigger sequencer: AXI4-Lite register slave, arming,
 readiness delay, step trigger and status flags.
 Assumes a single 10 MHz clock; host keeps AXI4-Lite handshake rules.
*/
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tss_defs.vh"

// Operation
// - No output change on trigger for an output not in step mode
// - Accepted trigger in step mode copies triggered level to immediate level
// - Fixed mode ignores triggers; immediate levels remain unchanged
// - Separate programmable triggered voltage and triggered current levels
// - Sequencer idles after reset and discards all triggers there
// - Initiate command arms sequencer, leaving idle to accept triggers
// - Triggers during the readiness interval after initiate are discarded
// - Waiting-for-trigger flag at condition bit 4 when ready
// - Trigger sources: transient trigger, common trigger, group execute
// - Abort command returns sequencer to idle without stepping
// - After applying step, sequencer returns to idle automatically
// - Transient-active flag at condition bit 6 while transient incomplete
// - At most one step per arming
module tss_sequencer #(
  parameter LEVEL_W = 16,
  parameter READY_CYCLES = `TSS_READY_CYC
) (
  input wire CLK,
  input wire NRST,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  output reg [LEVEL_W-1:0] IMM_VOLTAGE,
  output reg [LEVEL_W-1:0] IMM_CURRENT,
  output reg WAITING_FOR_TRIGGER_FLAG,
  output reg TRANSIENT_ACTIVE_FLAG,
  output reg IRQ
);

  // ==========================================================
  // States
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ARMING = 4'b0010;
  localparam [3:0] ST_WAIT = 4'b0100;
  localparam [3:0] ST_APPLY = 4'b1000;

  reg [3:0] state_q;
  reg [31:0] ready_cnt_q;
  reg [1:0] ctrl_q;
  reg [LEVEL_W-1:0] trg_v_q;
  reg [LEVEL_W-1:0] trg_i_q;
  reg [3:0] irq_stat_q;
  reg [3:0] irq_en_q;

  // ==========================================================
  // Write channel: address and data may come in either order
  reg aw_held_q;
  reg w_held_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID && S_AXI_WREADY;
  wire [7:0] wr_addr = aw_take ? S_AXI_AWADDR : aw_addr_q;
  wire [31:0] wr_data = w_take ? S_AXI_WDATA : w_data_q;
  wire [3:0] wr_strb = w_take ? S_AXI_WSTRB : w_strb_q;
  wire wr_fire = (aw_take || aw_held_q) && (w_take || w_held_q) && !S_AXI_BVALID;
  wire wr_hit = wr_fire && (wr_addr[1:0] == 2'h0);
  wire lo_en = wr_strb[0];

  // Writable offsets only; status is read-only, so a write there errors
  reg wr_dec_ok;
  always @* begin
    case (wr_addr)
      `TSS_OFF_CTRL, `TSS_OFF_CMD, `TSS_OFF_IMM_V, `TSS_OFF_IMM_I,
      `TSS_OFF_TRG_V, `TSS_OFF_TRG_I, `TSS_OFF_IRQ_EN, `TSS_OFF_IRQ_CLR: wr_dec_ok = 1'b1;
      default: wr_dec_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // One write strobe per register; control bits live in byte 0
  wire wr_ctrl = wr_hit && (wr_addr == `TSS_OFF_CTRL) && lo_en;
  wire wr_cmd = wr_hit && (wr_addr == `TSS_OFF_CMD) && lo_en;
  wire wr_imm_v = wr_hit && (wr_addr == `TSS_OFF_IMM_V);
  wire wr_imm_i = wr_hit && (wr_addr == `TSS_OFF_IMM_I);
  wire wr_trg_v = wr_hit && (wr_addr == `TSS_OFF_TRG_V);
  wire wr_trg_i = wr_hit && (wr_addr == `TSS_OFF_TRG_I);
  wire wr_irq_en = wr_hit && (wr_addr == `TSS_OFF_IRQ_EN) && lo_en;
  wire wr_irq_clr = wr_hit && (wr_addr == `TSS_OFF_IRQ_CLR) && lo_en;

  // Ready is withheld while a response is pending
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
    end else begin
      S_AXI_AWREADY <= !aw_held_q && !aw_take && !S_AXI_BVALID && !wr_fire;
      S_AXI_WREADY <= !w_held_q && !w_take && !S_AXI_BVALID && !wr_fire;
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_dec_ok ? 2'h0 : 2'h2;
      end else begin
        if (aw_take) begin
          aw_held_q <= 1'b1;
          aw_addr_q <= S_AXI_AWADDR;
        end
        if (w_take) begin
          w_held_q <= 1'b1;
          w_data_q <= S_AXI_WDATA;
          w_strb_q <= S_AXI_WSTRB;
        end
        if (S_AXI_BVALID && S_AXI_BREADY) begin
          S_AXI_BVALID <= 1'b0;
        end
      end
    end
  end

  // Byte-lane merge; lanes above the level width are dropped
  function [LEVEL_W-1:0] merge;
    input [LEVEL_W-1:0] old;
    input [31:0] data;
    input [3:0] strb;
    reg [31:0] tmp;
    integer b;
    begin
      tmp = 32'h00000000;
      tmp[LEVEL_W-1:0] = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          tmp[b*8 +: 8] = data[b*8 +: 8];
        end
      end
      merge = tmp[LEVEL_W-1:0];
    end
  endfunction

  // ==========================================================
  // Command strobes, one cycle each
  wire cmd_init = wr_cmd && wr_data[`TSS_CMD_INIT_BIT];
  wire cmd_abort = wr_cmd && wr_data[`TSS_CMD_ABORT_BIT];
  // Three trigger sources, all equivalent
  wire src_tran = wr_cmd && wr_data[`TSS_CMD_TRIG_BIT];
  wire src_common = wr_cmd && wr_data[`TSS_CMD_STRG_BIT];
  wire src_group = wr_cmd && wr_data[`TSS_CMD_GET_BIT];
  wire cmd_trig = src_tran || src_common || src_group;
  // Abort outranks a trigger in the same write
  wire trig_ok = (state_q == ST_WAIT) && cmd_trig && !cmd_abort;
  // Triggers outside the waiting state are dropped
  wire trig_drop = cmd_trig && !trig_ok;

  // ==========================================================
  // Sequencer
  // Initiate while armed is ignored; only abort leaves early
  reg [3:0] state_d;
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_init && !cmd_abort) state_d = ST_ARMING;
      end
      ST_ARMING: begin
        if (cmd_abort) state_d = ST_IDLE;
        else if (ready_cnt_q >= READY_CYCLES - 1) state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (cmd_abort) state_d = ST_IDLE;
        else if (trig_ok) state_d = ST_APPLY;
      end
      ST_APPLY: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Readiness counter: 32 bits so a long interval cannot wrap
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ready_cnt_q <= 32'h00000000;
    end else if (state_q == ST_ARMING) begin
      ready_cnt_q <= ready_cnt_q + 32'h00000001;
    end else begin
      ready_cnt_q <= 32'h00000000;
    end
  end

  // ==========================================================
  // Levels and mode registers
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_q <= `TSS_RST_CTRL;
      trg_v_q <= `TSS_RST_LEVEL;
      trg_i_q <= `TSS_RST_LEVEL;
      irq_en_q <= `TSS_RST_IRQ;
    end else begin
      if (wr_ctrl) ctrl_q <= wr_data[1:0];
      if (wr_trg_v) trg_v_q <= merge(trg_v_q, wr_data, wr_strb);
      if (wr_trg_i) trg_i_q <= merge(trg_i_q, wr_data, wr_strb);
      if (wr_irq_en) irq_en_q <= wr_data[3:0];
    end
  end

  // ==========================================================
  // Immediate setpoints; a step outranks a host write in the same cycle
  wire step_v = (state_q == ST_APPLY) && ctrl_q[`TSS_CTRL_VMODE_BIT];
  wire step_i = (state_q == ST_APPLY) && ctrl_q[`TSS_CTRL_IMODE_BIT];

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      IMM_VOLTAGE <= `TSS_RST_LEVEL;
      IMM_CURRENT <= `TSS_RST_LEVEL;
    end else begin
      // Fixed-mode outputs keep their level through a step
      if (step_v) begin
        IMM_VOLTAGE <= trg_v_q;
      end else if (wr_imm_v) begin
        IMM_VOLTAGE <= merge(IMM_VOLTAGE, wr_data, wr_strb);
      end
      if (step_i) begin
        IMM_CURRENT <= trg_i_q;
      end else if (wr_imm_i) begin
        IMM_CURRENT <= merge(IMM_CURRENT, wr_data, wr_strb);
      end
    end
  end

  // ==========================================================
  // Status flags and interrupts
  wire ev_ready = (state_q == ST_ARMING) && (state_d == ST_WAIT);
  wire ev_step = (state_q == ST_APPLY);
  wire ev_abort = cmd_abort && (state_q != ST_IDLE);
  wire [3:0] irq_set;
  wire [3:0] irq_clr = wr_irq_clr ? wr_data[3:0] : 4'h0;
  wire [3:0] irq_stat_d;
  assign irq_set[`TSS_IRQ_READY_BIT] = ev_ready;
  assign irq_set[`TSS_IRQ_STEP_BIT] = ev_step;
  assign irq_set[`TSS_IRQ_DROP_BIT] = trig_drop;
  assign irq_set[`TSS_IRQ_ABORT_BIT] = ev_abort;

  // Sticky bits: an event outranks a clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_stat
      assign irq_stat_d[g] = irq_set[g] | (irq_stat_q[g] & ~irq_clr[g]);
    end
  endgenerate

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      irq_stat_q <= `TSS_RST_IRQ;
      WAITING_FOR_TRIGGER_FLAG <= 1'b0;
      TRANSIENT_ACTIVE_FLAG <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      irq_stat_q <= irq_stat_d;
      WAITING_FOR_TRIGGER_FLAG <= (state_d == ST_WAIT);
      TRANSIENT_ACTIVE_FLAG <= (state_d != ST_IDLE);
      IRQ <= |(irq_stat_d & irq_en_q);
    end
  end

  // ==========================================================
  // Read channel
  reg [31:0] rd_val;
  reg rd_ok;
  always @* begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    case (S_AXI_ARADDR)
      `TSS_OFF_CTRL: rd_val[1:0] = ctrl_q;
      `TSS_OFF_CMD: rd_val = 32'h00000000;
      `TSS_OFF_IMM_V: rd_val[LEVEL_W-1:0] = IMM_VOLTAGE;
      `TSS_OFF_IMM_I: rd_val[LEVEL_W-1:0] = IMM_CURRENT;
      `TSS_OFF_TRG_V: rd_val[LEVEL_W-1:0] = trg_v_q;
      `TSS_OFF_TRG_I: rd_val[LEVEL_W-1:0] = trg_i_q;
      `TSS_OFF_OPER_COND: begin
        rd_val[`TSS_COND_WTG_BIT] = WAITING_FOR_TRIGGER_FLAG;
        rd_val[`TSS_COND_ACTIVE_BIT] = TRANSIENT_ACTIVE_FLAG;
      end
      `TSS_OFF_IRQ_STAT: rd_val[3:0] = irq_stat_q;
      `TSS_OFF_IRQ_EN: rd_val[3:0] = irq_en_q;
      `TSS_OFF_IRQ_CLR: rd_val = 32'h00000000;
      default: rd_ok = 1'b0;
    endcase
  end

  // Data latched at the address take; it stands until taken
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= 2'h0;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_val;
        S_AXI_RRESP <= rd_ok ? 2'h0 : 2'h2;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* File: test/tss_props.sv */
/* Checker: flag timing and register bus answers of the sequencer.
 Assumes bind to tss_sequencer and a single clock domain. */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checker
module tss_props #(
  parameter READY_CYCLES = 20
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic WAITING_FOR_TRIGGER_FLAG,
  input wire logic TRANSIENT_ACTIVE_FLAG
);
  wire wt = WAITING_FOR_TRIGGER_FLAG;
  wire ac = TRANSIENT_ACTIVE_FLAG;
  logic [15:0] cnt_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Cycles armed but not yet ready
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) cnt_q <= 16'h0;
    else if (ac && !wt) cnt_q <= cnt_q + 16'h1;
    else cnt_q <= 16'h0;
  end
  property p_wait_active; wt |-> ac; endproperty
  a_wait_active: assert property (p_wait_active) else $error("waiting without active");
  property p_arm_first; $rose(ac) |-> !wt [*8]; endproperty
  a_arm_first: assert property (p_arm_first) else $error("ready too early");
  property p_ready_time; $rose(wt) |-> cnt_q >= READY_CYCLES - 1 && cnt_q <= READY_CYCLES; endproperty
  a_ready_time: assert property (p_ready_time) else $error("readiness interval wrong");
  property p_step_end; $fell(wt) && ac |=> !ac; endproperty
  a_step_end: assert property (p_step_end) else $error("no return to idle");
  property p_idle_stays; !ac |=> !wt; endproperty
  a_idle_stays: assert property (p_idle_stays) else $error("waiting from idle");
  property p_r_lat; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_r_end; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID; endproperty
  a_r_end: assert property (p_r_end) else $error("read answer repeated");
  property p_b_end; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
  a_b_end: assert property (p_b_end) else $error("write answer repeated");
endmodule
bind tss_sequencer tss_props #(.READY_CYCLES(READY_CYCLES)) i_props (.CLK(CLK), .NRST(NRST),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .WAITING_FOR_TRIGGER_FLAG(WAITING_FOR_TRIGGER_FLAG),
  .TRANSIENT_ACTIVE_FLAG(TRANSIENT_ACTIVE_FLAG));
`default_nettype wire

/* File: test/tss_host.sv */
/* Host model: AXI4-Lite master for register access.
 Assumes one access at a time, started by the bench. */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Register bus master
module tss_host (
  input wire logic clk,
  output logic [7:0] awa,
  output logic awv,
  input wire logic awr,
  output logic [31:0] wda,
  output logic [3:0] wst,
  output logic wv,
  input wire logic wrd,
  input wire logic [1:0] bre,
  input wire logic bv,
  output logic bry,
  output logic [7:0] ara,
  output logic arv,
  input wire logic arr,
  input wire logic [31:0] rda,
  input wire logic [1:0] rre,
  input wire logic rv,
  output logic rry
);
  initial begin
    {awa, awv, wda, wv, bry, ara, arv, rry} = 'h0;
    wst = 4'hf;
  end
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clk);
    {awa, wda} <= {a, d};
    {awv, wv, bry} <= 3'h7;
    while (!ad || !dd) begin
      @(posedge clk);
      // Released lines show inverted data
      if (awr && !ad) begin
        ad = 1'b1;
        awv <= 1'b0;
        awa <= ~a;
      end
      if (wrd && !dd) begin
        dd = 1'b1;
        wv <= 1'b0;
        wda <= ~d;
      end
    end
    while (!bv) @(posedge clk);
    r = bre;
    bry <= 1'b0;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ara <= a;
    {arv, rry} <= 2'h3;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    ara <= ~a;
    while (!rv) @(posedge clk);
    {d, r} = {rda, rre};
    rry <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
/* Bench: arms, triggers and aborts the sequencer through the host model.
 Assumes READY_CYCLES set to 20 and the offsets of tss_defs.vh. */
`timescale 1ns/1ps
`default_nettype none
`include "tss_defs.vh"
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] rsp;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  wire [7:0] awa, ara;
  wire [31:0] wda, rda;
  wire [3:0] wst;
  wire [1:0] bre, rre;
  wire [15:0] imv, imi;
  wire awv, awr, wv, wrd, bv, bry, arv, arr, rv, rry, wtg, act, irq;
  always #50 clk = ~clk;
  tss_sequencer #(.READY_CYCLES(20)) i_dut (.CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wda), .S_AXI_WSTRB(wst),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bre), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rda), .S_AXI_RRESP(rre), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
    .IMM_VOLTAGE(imv), .IMM_CURRENT(imi), .WAITING_FOR_TRIGGER_FLAG(wtg),
    .TRANSIENT_ACTIVE_FLAG(act), .IRQ(irq));
  tss_host i_host (.clk(clk), .awa(awa), .awv(awv), .awr(awr), .wda(wda), .wst(wst), .wv(wv),
    .wrd(wrd), .bre(bre), .bv(bv), .bry(bry), .ara(ara), .arv(arv), .arr(arr), .rda(rda),
    .rre(rre), .rv(rv), .rry(rry));
  // ==========================================
  // Shared tasks
  task end_sim;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_host.write_reg(a, d, rsp);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    i_host.read_reg(a, d, rsp);
    chk("rdata", d, e);
  endtask
  // Bounded wait on the ready flag
  task wt(input logic e);
    int n;
    n = 0;
    while (wtg !== e && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("waiting", wtg, e);
  endtask
  // ==========================================
  // Scenarios
  task t_idle;
    rd(`TSS_OFF_OPER_COND, 32'h0);
    wr(`TSS_OFF_CTRL, 32'h3);
    wr(`TSS_OFF_TRG_V, 32'h1234);
    wr(`TSS_OFF_CMD, 32'h4);
    repeat (3) @(posedge clk);
    chk("idle", {imv, act}, 17'h0);
    rd(8'h40, 32'h0);
    chk("rresp", rsp, 2'h2);
  endtask
  task t_step(input int b, input logic [1:0] m, input logic [15:0] v, input logic [15:0] c);
    logic [15:0] v0;
    logic [15:0] c0;
    {v0, c0} = {imv, imi};
    wr(`TSS_OFF_CTRL, {30'h0, m});
    wr(`TSS_OFF_TRG_V, {16'h0, v});
    wr(`TSS_OFF_TRG_I, {16'h0, c});
    wr(`TSS_OFF_CMD, 32'h1);
    wr(`TSS_OFF_CMD, 32'h1 << b);
    repeat (2) @(posedge clk);
    chk("early", {imv, imi}, {v0, c0});
    chk("early_flags", {wtg, act}, 2'h1);
    wt(1'b1);
    rd(`TSS_OFF_OPER_COND, 32'h50);
    wr(`TSS_OFF_CMD, 32'h1 << b);
    wt(1'b0);
    repeat (2) @(posedge clk);
    chk("active", act, 1'b0);
    chk("imm", {imv, imi}, {m[0] ? v : v0, m[1] ? c : c0});
    wr(`TSS_OFF_TRG_V, {16'h0, ~v});
    wr(`TSS_OFF_CMD, 32'h1 << b);
    repeat (3) @(posedge clk);
    chk("again", imv, m[0] ? v : v0);
  endtask
  task t_abort;
    logic [15:0] v0;
    logic [15:0] c0;
    {v0, c0} = {imv, imi};
    wr(`TSS_OFF_CTRL, 32'h3);
    wr(`TSS_OFF_TRG_V, {16'h0, ~v0});
    wr(`TSS_OFF_TRG_I, {16'h0, ~c0});
    wr(`TSS_OFF_CMD, 32'h1);
    wr(`TSS_OFF_CMD, 32'h2);
    repeat (25) @(posedge clk);
    chk("abort_arm", {act, wtg}, 2'h0);
    wr(`TSS_OFF_CMD, 32'h1);
    wt(1'b1);
    wr(`TSS_OFF_CMD, 32'h2);
    repeat (2) @(posedge clk);
    chk("abort", {act, wtg, imv}, {2'h0, v0});
    chk("abort_i", imi, c0);
  endtask
  task t_irq;
    wr(`TSS_OFF_IRQ_CLR, 32'hf);
    wr(`TSS_OFF_IRQ_EN, 32'hf);
    chk("irq_off", irq, 1'b0);
    wr(`TSS_OFF_CMD, 32'h1);
    wt(1'b1);
    repeat (2) @(posedge clk);
    chk("irq_on", irq, 1'b1);
    rd(`TSS_OFF_IRQ_STAT, 32'h1);
    wr(`TSS_OFF_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq_mask", irq, 1'b0);
    wr(`TSS_OFF_CMD, 32'h2);
    rd(`TSS_OFF_IRQ_STAT, 32'h9);
    wr(`TSS_OFF_IRQ_CLR, 32'hf);
    rd(`TSS_OFF_IRQ_STAT, 32'h0);
    wr(`TSS_OFF_CMD, 32'h1);
    wt(1'b1);
    wr(`TSS_OFF_CMD, 32'h4);
    wr(`TSS_OFF_CMD, 32'h4);
    rd(`TSS_OFF_IRQ_STAT, 32'h7);
    chk("irq_masked", irq, 1'b0);
  endtask
  // ==========================================
  // Main sequence and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_idle;
    t_step(2, 2'h3, 16'h1234, 16'h00ab);
    t_step(3, 2'h1, 16'h0f0f, 16'h0055);
    t_step(4, 2'h2, 16'h7001, 16'h0c30);
    t_abort;
    t_irq;
    end_sim;
  end
endmodule
`default_nettype wire
